// ===== logic/tmi_pkg.sv
`default_nettype none
package tmi_pkg;
  // ==========================================================================
  // register byte addresses (word aligned)
  localparam logic [7:0] TMI_ADDR_RUN    = 8'h00; // timer_run_control_reg
  localparam logic [7:0] TMI_ADDR_PRESC  = 8'h04; // prescaler_reset_reg
  localparam logic [7:0] TMI_ADDR_PCLK   = 8'h08; // peripheral_clock_reg
  localparam logic [7:0] TMI_ADDR_PSTOP  = 8'h0C; // peripheral_clock_stop_reg
  localparam logic [7:0] TMI_ADDR_POL    = 8'h10; // output_polarity_reg
  localparam logic [7:0] TMI_ADDR_MODE0  = 8'h20; // channel_mode_reg, ch0
  localparam logic [7:0] TMI_ADDR_CSS0   = 8'h40; // count_source_select_reg
  localparam logic [7:0] TMI_ADDR_TMR0   = 8'h60; // timer_count_reload_reg
  localparam logic [7:0] TMI_ADDR_SEC0   = 8'h80; // secondary_reload_reg
  // ==========================================================================
  // channel_mode_reg fields
  localparam int TMI_MR_MODE_LSB  = 0;
  localparam int TMI_MR_PULSE     = 2;
  localparam int TMI_MR_GATE_LSB  = 3;
  localparam int TMI_MR_SRC_LSB   = 6;
  localparam logic [1:0] TMI_MODE_INTERVAL = 2'h0;
  localparam logic [1:0] TMI_GATE_LOW  = 2'h2;
  localparam logic [1:0] TMI_GATE_HIGH = 2'h3;
  // count_source_select_reg: bit 3 extended enable, bits 2:0 code
  localparam int TMI_CS_EXT = 3;
  localparam logic [2:0] TMI_EXT_F1   = 3'h0;
  localparam logic [2:0] TMI_EXT_F8   = 3'h1;
  localparam logic [2:0] TMI_EXT_F32  = 3'h2;
  localparam logic [2:0] TMI_EXT_F64  = 3'h3;
  localparam logic [2:0] TMI_EXT_OCO  = 3'h5;
  localparam logic [2:0] TMI_EXT_SUB  = 3'h6;
  localparam logic [1:0] TMI_SRC_F1F2 = 2'h0;
  localparam logic [1:0] TMI_SRC_F8   = 2'h1;
  localparam logic [1:0] TMI_SRC_F32  = 2'h2;
  localparam logic [1:0] TMI_SRC_SUB  = 2'h3;
  // ==========================================================================
  localparam logic [7:0]  TMI_RST_BYTE  = 8'h00;
  localparam logic [15:0] TMI_RST_COUNT = 16'h0000;
  localparam logic [7:0]  TMI_RST_PSTOP = 8'h00;
  localparam int TMI_ACK_CYCLES = 1;
  typedef enum logic [2:0] {
    TMI_T_OFF  = 3'h0, TMI_T_F1  = 3'h1, TMI_T_F2  = 3'h2, TMI_T_F8 = 3'h3,
    TMI_T_F32  = 3'h4, TMI_T_F64 = 3'h5, TMI_T_OCO = 3'h6, TMI_T_SUB = 3'h7
  } tmi_src_t;
endpackage : tmi_pkg
`default_nettype wire

// ===== logic/tmi_timer.sv
// Summary of operation
// - interval mode counts one of seven internal sources only
// - 16-bit counter decrements per tick, reloads on underflow, keeps going
// - underflow period is n+1 ticks for any n from 0000h to FFFFh
// - writing 1 to the run bit starts the channel
// - writing 0 to the run bit stops the channel
// - each underflow raises the channel interrupt request
// - reading the timer register returns the live counter
// - stopped: timer write loads both counter and reload register
// - counting: timer write loads reload register only, counter at next reload; before the first tick after start it loads the counter too
// - gate option lets the input pin level suspend counting
// - pulse output toggles the output pin on every underflow
// - normal polarity: output low while the run bit is 0
// - inverted polarity: output high while the run bit is 0
// - writing 1 to the prescaler reset bit clears the divider
// - secondary reload register is unused in interval mode
// - gate field 10 counts while pin low, 11 while pin high
// - operation mode field 00 selects interval mode
// - mode source bits act only when extended select is 0
// - reload on tick after reaching 0000h; first tick after start counts
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tmi_timer
  import tmi_pkg::*;
#(
  parameter int NCH = 5
) (
  input  wire logic           sys_clk,
  input  wire logic           srst,
  input  wire logic           clk_en,
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  input  wire logic           slow_onchip_oscillator,
  input  wire logic           sub_clock_source,
  input  wire logic [NCH-1:0] timer_gate_input_pin,
  output logic      [NCH-1:0] timer_pulse_output_pin,
  output logic      [NCH-1:0] timer_pulse_output_oe,
  output logic      [NCH-1:0] timer_irq
);
  // ==========================================================================
  // bus decode
  logic [NCH-1:0] run;
  logic           halved_clock_select_bit;
  logic           base_clock_stop_bit;
  logic [NCH-1:0] pol;
  logic [7:0]     mode   [NCH];
  logic [7:0]     css    [NCH];
  logic [15:0]    cnt    [NCH];
  logic [15:0]    rld    [NCH];
  logic [15:0]    sec    [NCH];
  logic [NCH-1:0] started;
  logic [5:0]     presc;
  logic           osc_q;
  logic           sub_q;
  logic           req;
  logic           wr;
  logic [31:0]    next_rdata;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  assign wr  = req && wb_we_i;

  function automatic logic [7:0] merge8(input logic [7:0] old);
    merge8 = wb_sel_i[0] ? wb_dat_i[7:0] : old;
  endfunction : merge8

  function automatic logic [15:0] merge16(input logic [15:0] old);
    merge16 = {wb_sel_i[1] ? wb_dat_i[15:8] : old[15:8],
               wb_sel_i[0] ? wb_dat_i[7:0]  : old[7:0]};
  endfunction : merge16

  // ==========================================================================
  // global control registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      run                     <= '0;
      halved_clock_select_bit <= 1'b0;
      base_clock_stop_bit     <= 1'b0;
      pol                     <= '0;
    end else if (wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        TMI_ADDR_RUN:   run <= wb_dat_i[NCH-1:0];
        TMI_ADDR_PCLK:  halved_clock_select_bit <= wb_dat_i[0];
        TMI_ADDR_PSTOP: base_clock_stop_bit <= wb_dat_i[0];
        TMI_ADDR_POL:   pol <= wb_dat_i[NCH-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // prescaler and tick strobes; slow sources are edge sampled
  logic tick_f1;
  logic tick_f2;
  logic tick_f8;
  logic tick_f32;
  logic tick_f64;
  logic tick_oco;
  logic tick_sub;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      presc <= '0;
      osc_q <= 1'b0;
      sub_q <= 1'b0;
    end else if (clk_en) begin
      osc_q <= slow_onchip_oscillator;
      sub_q <= sub_clock_source;
      if (wr && wb_adr_i == TMI_ADDR_PRESC && wb_sel_i[0] && wb_dat_i[0])
        presc <= '0;
      else if (!base_clock_stop_bit)
        presc <= presc + 6'h01;
    end
  end

  // f1 is gated off by the stop bit, software must keep it at 0
  assign tick_f1  = !base_clock_stop_bit;
  assign tick_f2  = tick_f1 && presc[0];
  assign tick_f8  = tick_f1 && (presc[2:0] == 3'h7);
  assign tick_f32 = tick_f1 && (presc[4:0] == 5'h1F);
  assign tick_f64 = tick_f1 && (presc == 6'h3F);
  assign tick_oco = slow_onchip_oscillator && !osc_q;
  assign tick_sub = sub_clock_source && !sub_q;

  // the halved-clock bit is an argument so the continuous assignment that
  // calls this function re-evaluates when software flips it
  function automatic tmi_src_t pick_src(input logic [7:0] m,
                                        input logic [7:0] c,
                                        input logic       h);
    tmi_src_t s;
    s = TMI_T_OFF;
    if (c[TMI_CS_EXT]) begin
      unique case (c[2:0])
        TMI_EXT_F1:  s = TMI_T_F1;
        TMI_EXT_F8:  s = TMI_T_F8;
        TMI_EXT_F32: s = TMI_T_F32;
        TMI_EXT_F64: s = TMI_T_F64;
        TMI_EXT_OCO: s = TMI_T_OCO;
        TMI_EXT_SUB: s = TMI_T_SUB;
        default:     s = TMI_T_OFF;
      endcase
    end else begin
      unique case (m[TMI_MR_SRC_LSB +: 2])
        TMI_SRC_F1F2: s = h ? TMI_T_F1 : TMI_T_F2;
        TMI_SRC_F8:   s = TMI_T_F8;
        TMI_SRC_F32:  s = TMI_T_F32;
        TMI_SRC_SUB:  s = TMI_T_SUB;
      endcase
    end
    pick_src = s;
  endfunction : pick_src

  // ==========================================================================
  // per-channel registers and counter
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      localparam logic [7:0] OFS = 8'(gi * 4);
      tmi_src_t src;
      logic     tick;
      logic     gate_ok;
      logic     counting;
      logic     mode_ok;
      logic     tmr_wr;
      logic [1:0] gsel;

      assign src  = pick_src(mode[gi], css[gi], halved_clock_select_bit);
      assign tick = (src == TMI_T_F1  && tick_f1)  ||
                    (src == TMI_T_F2  && tick_f2)  ||
                    (src == TMI_T_F8  && tick_f8)  ||
                    (src == TMI_T_F32 && tick_f32) ||
                    (src == TMI_T_F64 && tick_f64) ||
                    (src == TMI_T_OCO && tick_oco) ||
                    (src == TMI_T_SUB && tick_sub);
      assign gsel    = mode[gi][TMI_MR_GATE_LSB +: 2];
      assign gate_ok = (gsel == TMI_GATE_LOW)  ? !timer_gate_input_pin[gi] :
                       (gsel == TMI_GATE_HIGH) ?  timer_gate_input_pin[gi] :
                       1'b1;
      assign mode_ok = mode[gi][TMI_MR_MODE_LSB +: 2] == TMI_MODE_INTERVAL;
      assign counting = run[gi] && mode_ok && gate_ok && clk_en;
      assign tmr_wr   = wr && wb_adr_i == TMI_ADDR_TMR0 + OFS;

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          mode[gi] <= TMI_RST_BYTE;
          css[gi]  <= TMI_RST_BYTE;
          sec[gi]  <= TMI_RST_COUNT;
        end else if (wr) begin
          if (wb_adr_i == TMI_ADDR_MODE0 + OFS) mode[gi] <= merge8(mode[gi]);
          if (wb_adr_i == TMI_ADDR_CSS0 + OFS)  css[gi]  <= merge8(css[gi]);
          // stored only, no effect on counting
          if (wb_adr_i == TMI_ADDR_SEC0 + OFS)  sec[gi]  <= merge16(sec[gi]);
        end
      end

      // started marks that the first tick after start has arrived, so a
      // write before it still loads the counter directly
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          cnt[gi]     <= TMI_RST_COUNT;
          rld[gi]     <= TMI_RST_COUNT;
          started[gi] <= 1'b0;
          timer_irq[gi] <= 1'b0;
          timer_pulse_output_pin[gi] <= 1'b0;
          timer_pulse_output_oe[gi]  <= 1'b0;
        end else if (clk_en) begin
          timer_irq[gi] <= 1'b0;
          timer_pulse_output_oe[gi] <= mode[gi][TMI_MR_PULSE];
          if (!run[gi]) begin
            started[gi] <= 1'b0;
            timer_pulse_output_pin[gi] <= pol[gi];
          end
          if (tmr_wr) begin
            rld[gi] <= merge16(rld[gi]);
            if (!started[gi] || !run[gi])
              cnt[gi] <= merge16(cnt[gi]);
          end
          if (counting && tick && !(tmr_wr && !started[gi])) begin
            started[gi] <= 1'b1;
            if (cnt[gi] == 16'h0000) begin
              cnt[gi] <= tmr_wr ? merge16(rld[gi]) : rld[gi];
              timer_irq[gi] <= 1'b1;
              if (mode[gi][TMI_MR_PULSE])
                timer_pulse_output_pin[gi] <= !timer_pulse_output_pin[gi];
            end else begin
              cnt[gi] <= cnt[gi] - 16'h0001;
            end
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read mux and single-cycle ack
  always_comb begin
    next_rdata = '0;
    unique case (wb_adr_i)
      TMI_ADDR_RUN:   next_rdata[NCH-1:0] = run;
      TMI_ADDR_PCLK:  next_rdata[0] = halved_clock_select_bit;
      TMI_ADDR_PSTOP: next_rdata[0] = base_clock_stop_bit;
      TMI_ADDR_POL:   next_rdata[NCH-1:0] = pol;
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (wb_adr_i == TMI_ADDR_MODE0 + 8'(i * 4))
            next_rdata[7:0] = mode[i];
          if (wb_adr_i == TMI_ADDR_CSS0 + 8'(i * 4))
            next_rdata[7:0] = css[i];
          if (wb_adr_i == TMI_ADDR_TMR0 + 8'(i * 4))
            next_rdata[15:0] = cnt[i];
          if (wb_adr_i == TMI_ADDR_SEC0 + 8'(i * 4))
            next_rdata[15:0] = sec[i];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clk_en) begin
      wb_ack_o <= req;
      wb_dat_o <= req ? next_rdata : 32'h0000_0000;
    end
  end
endmodule : tmi_timer
`default_nettype wire

// ===== testbench/tmi_timer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module tmi_timer_chk
  import tmi_pkg::*;
#(
  parameter int NCH = 5
) (
  input wire logic           sys_clk,
  input wire logic           srst,
  input wire logic           clk_en,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_we_i,
  input wire logic [7:0]     wb_adr_i,
  input wire logic [3:0]     wb_sel_i,
  input wire logic [31:0]    wb_dat_i,
  input wire logic [31:0]    wb_dat_o,
  input wire logic           wb_ack_o,
  input wire logic           slow_onchip_oscillator,
  input wire logic           sub_clock_source,
  input wire logic [NCH-1:0] timer_gate_input_pin,
  input wire logic [NCH-1:0] timer_pulse_output_pin,
  input wire logic [NCH-1:0] timer_pulse_output_oe,
  input wire logic [NCH-1:0] timer_irq
);
  // ==========================================================================
  // shadows of run and polarity; quiet lets registered outputs settle
  logic       run_sh;
  logic       pol_sh;
  logic [1:0] quiet;
  logic       wr_ack;
  assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      run_sh <= 1'b0;
      pol_sh <= 1'b0;
      quiet  <= 2'h0;
    end else if (wr_ack) begin
      if (wb_adr_i == TMI_ADDR_RUN) run_sh <= wb_dat_i[0];
      if (wb_adr_i == TMI_ADDR_POL) pol_sh <= wb_dat_i[0];
      quiet <= 2'h0;
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_pulse: assert property (
    wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  a_oe_follows: assert property (
    wr_ack && wb_adr_i == TMI_ADDR_MODE0 |-> ##2
    timer_pulse_output_oe[0] == $past(wb_dat_i[TMI_MR_PULSE], 2))
    else $error("output enable not from mode");
  a_out_idle: assert property (
    quiet == 2'h3 && !run_sh |-> timer_pulse_output_pin[0] == pol_sh)
    else $error("idle output level wrong");
  a_irq_stopped: assert property (
    quiet == 2'h3 && !run_sh |-> !timer_irq[0]) else $error("irq while stopped");
  a_toggle_on_irq: assert property (
    quiet == 2'h3 && run_sh && timer_pulse_output_oe[0] && timer_irq[0]
    |-> ##[0:1] $changed(timer_pulse_output_pin[0]))
    else $error("no toggle on underflow");
  a_toggle_cause: assert property (
    quiet == 2'h3 && run_sh && $changed(timer_pulse_output_pin[0])
    |-> timer_irq[0] || $past(timer_irq[0])) else $error("toggle without irq");
endmodule : tmi_timer_chk
bind tmi_timer tmi_timer_chk #(.NCH(NCH)) chk_u (
  .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .slow_onchip_oscillator(slow_onchip_oscillator),
  .sub_clock_source(sub_clock_source),
  .timer_gate_input_pin(timer_gate_input_pin),
  .timer_pulse_output_pin(timer_pulse_output_pin),
  .timer_pulse_output_oe(timer_pulse_output_oe), .timer_irq(timer_irq));
`default_nettype wire

// ===== testbench/tmi_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tmi_timer_tb
  import tmi_pkg::*;
;
  logic        sys_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, o1;
  logic        osc = 0, sub = 0, ack, en = 1;
  int          oc = 0, sc = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [4:0]  gate = 0, pout, poe, irq;
  int          fail_count = 0, n_tests = 0, p, i, g;
  // pclk, source select, mode source, expected cycles per underflow with n = 0
  int          tab [11][4] = '{'{1,0,0,1}, '{0,0,0,2}, '{1,0,1,8},
    '{1,0,2,32}, '{1,0,3,15}, '{1,9,2,8}, '{1,11,0,64}, '{1,13,0,11},
    '{1,14,0,15}, '{1,8,0,1}, '{1,10,0,32}};
  always #10 sys_clk = ~sys_clk;
  // slow sources driven on the clock edge, rising every 11 and 15 cycles
  always @(posedge sys_clk) begin
    oc <= (oc == 10) ? 0 : oc + 1;
    sc <= (sc == 14) ? 0 : sc + 1;
    osc <= (oc < 5);
    sub <= (sc < 7);
  end
  tmi_timer dut_u (.sys_clk(sys_clk), .srst(srst), .clk_en(en),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .slow_onchip_oscillator(osc), .sub_clock_source(sub),
    .timer_gate_input_pin(gate), .timer_pulse_output_pin(pout),
    .timer_pulse_output_oe(poe), .timer_irq(irq));
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input int d);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= (a >= 8'h60) ? 4'h3 : 4'h1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) fail_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
  task automatic per(output int n);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (irq[0] !== 1'b1 && k < 3000);
    o1 = pout[0];
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (irq[0] !== 1'b1 && n < 3000);
  endtask : per
  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // ==========================================================================
  initial begin
    #1000000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    xfer(0, TMI_ADDR_TMR0, 0);
    chk(q, {16'h0, TMI_RST_COUNT});
    xfer(0, 8'hFC, 0);
    chk(q, 0);
    xfer(1, TMI_ADDR_PSTOP, 0);
    xfer(1, TMI_ADDR_PRESC, 1);
    xfer(1, TMI_ADDR_SEC0, 32'h1234);
    xfer(1, TMI_ADDR_PCLK, 1);
    xfer(1, TMI_ADDR_TMR0, 5);
    xfer(0, TMI_ADDR_TMR0, 0);
    chk(q, 5);
    xfer(1, TMI_ADDR_MODE0, 4);
    xfer(1, TMI_ADDR_RUN, 1);
    per(p);
    per(p);
    chk(p, 6);
    chk(pout[0], !o1);
    xfer(0, TMI_ADDR_TMR0, 0);
    chk(q > 5, 0);
    xfer(1, TMI_ADDR_TMR0, 9);
    per(p);
    per(p);
    chk(p, 10);
    xfer(1, TMI_ADDR_RUN, 0);
    xfer(1, TMI_ADDR_TMR0, 7);
    repeat (5) @(negedge sys_clk);
    xfer(0, TMI_ADDR_TMR0, 0);
    chk(q, 7);
    chk(pout[0], 0);
    xfer(1, TMI_ADDR_POL, 1);
    repeat (3) @(negedge sys_clk);
    chk(pout[0], 1);
    xfer(1, TMI_ADDR_POL, 0);
    xfer(1, TMI_ADDR_MODE0, 1);
    xfer(1, TMI_ADDR_RUN, 1);
    repeat (10) @(negedge sys_clk);
    xfer(0, TMI_ADDR_TMR0, 0);
    chk(q, 7);
    for (g = 2; g < 4; g++) begin
      xfer(1, TMI_ADDR_RUN, 0);
      xfer(1, TMI_ADDR_TMR0, 7);
      xfer(1, TMI_ADDR_MODE0, (g << 3) | 4);
      gate[0] <= (g == 2);
      xfer(1, TMI_ADDR_RUN, 1);
      repeat (10) @(negedge sys_clk);
      xfer(0, TMI_ADDR_TMR0, 0);
      chk(q, 7);
      gate[0] <= (g == 3);
      repeat (3) @(negedge sys_clk);
      xfer(0, TMI_ADDR_TMR0, 0);
      chk(q == 7, 0);
    end
    xfer(1, TMI_ADDR_RUN, 0);
    xfer(1, TMI_ADDR_TMR0, 0);
    xfer(1, TMI_ADDR_RUN, 1);
    for (i = 0; i < 11; i++) begin
      xfer(1, TMI_ADDR_PCLK, tab[i][0]);
      xfer(1, TMI_ADDR_CSS0, tab[i][1]);
      xfer(1, TMI_ADDR_MODE0, tab[i][2] << 6);
      per(p);
      per(p);
      chk(p, tab[i][3]);
    end
    // clock enable low must freeze the counter as well as the bus
    xfer(1, TMI_ADDR_RUN, 0);
    xfer(1, TMI_ADDR_TMR0, 50);
    xfer(1, TMI_ADDR_CSS0, 8);
    xfer(1, TMI_ADDR_RUN, 1);
    @(posedge sys_clk);
    en <= 1'b0;
    repeat (20) @(posedge sys_clk);
    en <= 1'b1;
    xfer(0, TMI_ADDR_TMR0, 0);
    chk(q > 40 && q <= 50, 1);
    complete_run();
  end
endmodule : tmi_timer_tb
`default_nettype wire
